// [core/spc_config_top.sv]
// Register bank and settling sequencer for scan polarity and auxiliary reference control
// Contract
// - Mode bit picks unipolar or bipolar extremes
// - One polarity bit per cell, reset unipolar
// - Bipolar cells fault masked in balance diagnostics
// - Bipolar cells use bipolar voltage thresholds
// - Bipolar cells excluded from comparator scans
// - Per-channel bit selects ratiometric or absolute
// - Generic I/O channel ignores reference bit
// - Two-wire mode ignores channels one and zero
// - Settling time is count times six microseconds
// - Settling inserted before every requested scan
// - Charge pump refreshed during idle settling
// - Auto mode drives bias only from acquisition
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module spc_config_top #(
	parameter int CELLS = spc_pkg::CELLS,
	parameter int AUXES = spc_pkg::AUXES,
	parameter int UNIT_CYCLES = spc_pkg::SETTLE_UNIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input spc_pkg::spc_bus_req_t bus_req,
	output logic [15:0] bus_rdata,
	input wire logic scan_request,
	input wire logic scan_done,
	input wire logic auto_mode,
	input wire logic other_scan_active,
	input wire logic balance_switch_diag_scan,
	input wire logic [AUXES-1:0] aux_pin_generic_io_enable,
	input wire logic aux_pin_two_wire_enable,
	output spc_pkg::spc_cell_ctrl_t cell_ctrl,
	output logic [CELLS-1:0] cell_bipolar,
	output logic extreme_calc_polarity_mode,
	output logic thermistor_bias_output,
	output logic high_voltage_charge_pump,
	output logic conversion_release,
	output logic settle_busy,
	output logic irq
);
	typedef struct packed {
		spc_pkg::spc_phase_t phase;
		logic [CELLS-1:0] polarity;
		logic mode;
		logic [AUXES-1:0] aux_ref;
		logic [spc_pkg::SETTLE_MSB:0] settle;
		logic [spc_pkg::EVT_W-1:0] status;
		logic [spc_pkg::EVT_W-1:0] mask;
		logic [15:0] rdata;
		logic release_q;
	} spc_main_st_t;

	spc_main_st_t st_reg;
	spc_main_st_t st_next;
	logic timer_running;
	logic timer_load;
	logic [spc_pkg::EVT_W-1:0] events;
	logic wr_status;

	assign timer_load = st_reg.phase == spc_pkg::SPC_IDLE && scan_request;

	spc_settle_timer #(
		.UNIT_CYCLES(UNIT_CYCLES),
		.COUNT_W(spc_pkg::SETTLE_MSB + 1)
	) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.load(timer_load),
		.load_value(st_reg.settle),
		.running(timer_running)
	);

	spc_cell_classifier #(
		.CELLS(CELLS),
		.AUXES(AUXES)
	) u_class (
		.ref_clk(ref_clk),
		.reset(reset),
		.cell_bipolar(st_reg.polarity),
		.extreme_calc_polarity_mode(st_reg.mode),
		.balance_switch_diag_scan(balance_switch_diag_scan),
		.aux_reference_select(st_reg.aux_ref),
		.aux_pin_generic_io_enable(aux_pin_generic_io_enable),
		.aux_pin_two_wire_enable(aux_pin_two_wire_enable),
		.cell_ctrl(cell_ctrl)
	);

	// A request while busy is dropped, never queued
	always_comb begin
		events = '0;
		events[spc_pkg::EVT_SETTLED] = st_reg.phase == spc_pkg::SPC_SETTLE && !timer_running;
		events[spc_pkg::EVT_OVERRUN] = st_reg.phase != spc_pkg::SPC_IDLE && scan_request;
	end

	assign wr_status = bus_req.wr && bus_req.addr == spc_pkg::ADDR_STATUS;

	always_comb begin
		st_next = st_reg;
		st_next.release_q = 1'b0;
		st_next.rdata = 16'h0000;
		case (st_reg.phase)
			spc_pkg::SPC_IDLE: begin
				if (scan_request) begin
					st_next.phase = spc_pkg::SPC_SETTLE;
				end
			end
			spc_pkg::SPC_SETTLE: begin
				if (!timer_running) begin
					st_next.phase = spc_pkg::SPC_CONVERT;
					st_next.release_q = 1'b1;
				end
			end
			spc_pkg::SPC_CONVERT: begin
				if (scan_done) begin
					st_next.phase = spc_pkg::SPC_IDLE;
				end
			end
			default: begin
				st_next.phase = spc_pkg::SPC_IDLE;
			end
		endcase
		if (bus_req.wr) begin
			case (bus_req.addr)
				spc_pkg::ADDR_POLARITY: begin
					st_next.polarity = bus_req.wdata[spc_pkg::POL_CELL_MSB:0];
					st_next.mode = bus_req.wdata[spc_pkg::POL_MODE_BIT];
				end
				spc_pkg::ADDR_AUX_REF: begin
					st_next.aux_ref = bus_req.wdata[spc_pkg::AUX_REF_MSB:0];
				end
				spc_pkg::ADDR_SETTLE: begin
					st_next.settle = bus_req.wdata[spc_pkg::SETTLE_MSB:0];
				end
				spc_pkg::ADDR_MASK: begin
					st_next.mask = bus_req.wdata[spc_pkg::EVT_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Set beats clear in the same cycle
		if (wr_status) begin
			st_next.status = (st_reg.status & ~bus_req.wdata[spc_pkg::EVT_W-1:0]) | events;
		end else begin
			st_next.status = st_reg.status | events;
		end
		if (bus_req.rd) begin
			case (bus_req.addr)
				spc_pkg::ADDR_POLARITY: begin
					st_next.rdata = {st_reg.mode, 1'b0, st_reg.polarity};
				end
				spc_pkg::ADDR_AUX_REF: begin
					st_next.rdata = {10'h000, st_reg.aux_ref};
				end
				spc_pkg::ADDR_SETTLE: begin
					st_next.rdata = {6'h00, st_reg.settle};
				end
				spc_pkg::ADDR_STATUS: begin
					st_next.rdata = {14'h0000, st_reg.status};
				end
				spc_pkg::ADDR_MASK: begin
					st_next.rdata = {14'h0000, st_reg.mask};
				end
				default: begin
					st_next.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_reg.phase <= spc_pkg::SPC_IDLE;
			st_reg.polarity <= spc_pkg::POL_CELL_RESET;
			st_reg.mode <= spc_pkg::POL_MODE_RESET;
			st_reg.aux_ref <= spc_pkg::AUX_REF_RESET;
			st_reg.settle <= spc_pkg::SETTLE_RESET;
			st_reg.status <= spc_pkg::EVT_RESET;
			st_reg.mask <= spc_pkg::EVT_RESET;
			st_reg.rdata <= 16'h0000;
			st_reg.release_q <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata = st_reg.rdata;
	assign cell_bipolar = st_reg.polarity;
	assign extreme_calc_polarity_mode = st_reg.mode;
	assign conversion_release = st_reg.release_q;
	assign settle_busy = st_reg.phase == spc_pkg::SPC_SETTLE;
	// Bias held off until the acquisition starts so settling counts from its edge
	assign thermistor_bias_output = !auto_mode || st_reg.phase != spc_pkg::SPC_IDLE;
	// Pump refresh yields to any other active measurement
	assign high_voltage_charge_pump = settle_busy && timer_running && !other_scan_active;
	assign irq = |(st_reg.status & st_reg.mask);

	a_extreme_pick: assert property (@(posedge ref_clk) disable iff (reset)
		##1 cell_ctrl.extreme_include == ~($past(st_reg.polarity) ^ {CELLS{$past(st_reg.mode)}}))
		else $error("extreme calculation set wrong");

	a_polarity_store: assert property (@(posedge ref_clk) disable iff (reset)
		(bus_req.wr && bus_req.addr == spc_pkg::ADDR_POLARITY) ##1 bus_req.rd
		&& bus_req.addr == spc_pkg::ADDR_POLARITY
		|=> bus_rdata[spc_pkg::POL_CELL_MSB:0] == $past(bus_req.wdata[13:0], 2))
		else $error("polarity readback mismatch");

	a_diag_mask: assert property (@(posedge ref_clk) disable iff (reset)
		##1 cell_ctrl.fault_mask == ($past(st_reg.polarity)
		& {CELLS{$past(balance_switch_diag_scan)}}))
		else $error("diagnostic fault mask wrong");

	a_bip_threshold: assert property (@(posedge ref_clk) disable iff (reset)
		##1 cell_ctrl.bipolar_threshold == $past(st_reg.polarity))
		else $error("threshold set wrong");

	a_comp_exclude: assert property (@(posedge ref_clk) disable iff (reset)
		##1 (cell_ctrl.comparator_enable & $past(st_reg.polarity)) == '0)
		else $error("bipolar cell in comparator scan");

	a_gpio_ignore: assert property (@(posedge ref_clk) disable iff (reset)
		##1 (cell_ctrl.aux_absolute & $past(aux_pin_generic_io_enable)) == '0)
		else $error("generic io channel uses reference bit");

	a_two_wire_ignore: assert property (@(posedge ref_clk) disable iff (reset)
		$past(aux_pin_two_wire_enable) |-> cell_ctrl.aux_absolute[1:0] == 2'h0
		&& cell_ctrl.aux_absolute[5:2] == ($past(st_reg.aux_ref[5:2])
		& ~$past(aux_pin_generic_io_enable[5:2])))
		else $error("two-wire channel select wrong");

	a_request_load: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.phase == spc_pkg::SPC_IDLE && scan_request && st_reg.settle != '0)
		|=> settle_busy ##1 timer_running)
		else $error("request did not start settling");

	a_release_order: assert property (@(posedge ref_clk) disable iff (reset)
		conversion_release |-> $past(settle_busy) && !$past(timer_running)
		&& st_reg.phase == spc_pkg::SPC_CONVERT)
		else $error("conversion released before settling");

	a_zero_settle: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.phase == spc_pkg::SPC_IDLE && scan_request && st_reg.settle == '0)
		|=> ##1 conversion_release)
		else $error("zero settling not immediate");

	a_pump_refresh: assert property (@(posedge ref_clk) disable iff (reset)
		high_voltage_charge_pump |-> settle_busy && !other_scan_active
		&& !conversion_release)
		else $error("pump refresh outside idle settling");

	a_bias_auto: assert property (@(posedge ref_clk) disable iff (reset)
		(auto_mode && st_reg.phase == spc_pkg::SPC_IDLE) |-> !thermistor_bias_output)
		else $error("bias driven before acquisition");

	a_event_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		conversion_release |-> st_reg.status[spc_pkg::EVT_SETTLED])
		else $error("settled event not recorded");

	a_overrun_flag: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.phase != spc_pkg::SPC_IDLE && scan_request)
		|=> st_reg.status[spc_pkg::EVT_OVERRUN])
		else $error("overrun event not recorded");

	a_busy_drop: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg.phase == spc_pkg::SPC_CONVERT && !scan_done)
		|=> st_reg.phase == spc_pkg::SPC_CONVERT)
		else $error("conversion phase left without done");

	a_status_clear: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_status && bus_req.wdata[spc_pkg::EVT_OVERRUN] && !events[spc_pkg::EVT_OVERRUN])
		|=> !st_reg.status[spc_pkg::EVT_OVERRUN])
		else $error("status bit not cleared by write");

	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
		!bus_req.rd |=> bus_rdata == 16'h0000)
		else $error("read data outside read cycle");

	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
		(bus_req.rd && bus_req.addr == spc_pkg::ADDR_POLARITY) |=> !bus_rdata[14])
		else $error("reserved polarity bit read back");

	a_mode_store: assert property (@(posedge ref_clk) disable iff (reset)
		(bus_req.wr && bus_req.addr == spc_pkg::ADDR_POLARITY)
		|=> extreme_calc_polarity_mode == $past(bus_req.wdata[spc_pkg::POL_MODE_BIT]))
		else $error("mode bit not stored");

	a_aux_store: assert property (@(posedge ref_clk) disable iff (reset)
		(bus_req.wr && bus_req.addr == spc_pkg::ADDR_AUX_REF)
		|=> st_reg.aux_ref == $past(bus_req.wdata[spc_pkg::AUX_REF_MSB:0]))
		else $error("reference select not stored");

	a_settle_store: assert property (@(posedge ref_clk) disable iff (reset)
		(bus_req.wr && bus_req.addr == spc_pkg::ADDR_SETTLE)
		|=> st_reg.settle == $past(bus_req.wdata[spc_pkg::SETTLE_MSB:0]))
		else $error("settle count not stored");

	a_bias_settle: assert property (@(posedge ref_clk) disable iff (reset)
		settle_busy |-> thermistor_bias_output)
		else $error("settling without bias applied");

	a_pump_on: assert property (@(posedge ref_clk) disable iff (reset)
		(settle_busy && timer_running && !other_scan_active) |-> high_voltage_charge_pump)
		else $error("pump not refreshed while idle settling");
endmodule

// [core/spc_pkg.sv]
// Shared constants and types for the scan polarity and auxiliary configuration block
package spc_pkg;
	localparam int CELLS = 14;
	localparam int AUXES = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_POLARITY = 8'h5F;
	localparam logic [7:0] ADDR_AUX_REF = 8'h60;
	localparam logic [7:0] ADDR_SETTLE = 8'h61;
	localparam logic [7:0] ADDR_STATUS = 8'h70;
	localparam logic [7:0] ADDR_MASK = 8'h71;
	localparam int POL_MODE_BIT = 15;
	localparam int POL_CELL_MSB = 13;
	localparam int AUX_REF_MSB = 5;
	localparam int SETTLE_MSB = 9;
	localparam int TWO_WIRE_MSB = 1;
	localparam logic [13:0] POL_CELL_RESET = 14'h0000;
	localparam logic POL_MODE_RESET = 1'h0;
	localparam logic [5:0] AUX_REF_RESET = 6'h00;
	localparam logic [9:0] SETTLE_RESET = 10'h000;
	localparam int EVT_SETTLED = 0;
	localparam int EVT_OVERRUN = 1;
	localparam int EVT_W = 2;
	localparam logic [1:0] EVT_RESET = 2'h0;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SETTLE_UNIT_US = 6;
	localparam int SETTLE_UNIT_CYCLES = SETTLE_UNIT_US * 1000000 / CLK_PERIOD_PS;
	localparam int PRESCALE_W = 11;
	typedef enum logic [1:0] {
		SPC_IDLE = 2'h0,
		SPC_SETTLE = 2'h1,
		SPC_CONVERT = 2'h3
	} spc_phase_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} spc_bus_req_t;
	typedef struct packed {
		logic [13:0] extreme_include;
		logic [13:0] fault_mask;
		logic [13:0] bipolar_threshold;
		logic [13:0] comparator_enable;
		logic [5:0] aux_absolute;
	} spc_cell_ctrl_t;
endpackage

// [core/spc_settle_timer.sv]
// Settling interval counter on a 6 us tick
`timescale 1ns/100ps
module spc_settle_timer #(
	parameter int UNIT_CYCLES = spc_pkg::SETTLE_UNIT_CYCLES,
	parameter int COUNT_W = spc_pkg::SETTLE_MSB + 1
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [COUNT_W-1:0] load_value,
	output logic running
);
	localparam logic [spc_pkg::PRESCALE_W-1:0] UNIT_LAST =
		spc_pkg::PRESCALE_W'(UNIT_CYCLES - 1);
	typedef struct packed {
		logic [spc_pkg::PRESCALE_W-1:0] prescale;
		logic [COUNT_W-1:0] count;
	} spc_timer_st_t;
	spc_timer_st_t st_reg;
	spc_timer_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.count = load_value;
			st_next.prescale = UNIT_LAST;
		end else if (st_reg.count != '0) begin
			if (st_reg.prescale == '0) begin
				st_next.count = st_reg.count - COUNT_W'(1);
				st_next.prescale = UNIT_LAST;
			end else begin
				st_next.prescale = st_reg.prescale - spc_pkg::PRESCALE_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign running = st_reg.count != '0;

	a_settle_hold: assert property (@(posedge ref_clk) disable iff (reset)
		(!load && st_reg.prescale != '0 && running) |=> $stable(st_reg.count))
		else $error("settle count moved between ticks");
endmodule

// [core/spc_cell_classifier.sv]
// Per-cell and per-channel routing derived from the polarity and reference settings
`timescale 1ns/100ps
module spc_cell_classifier #(
	parameter int CELLS = spc_pkg::CELLS,
	parameter int AUXES = spc_pkg::AUXES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [CELLS-1:0] cell_bipolar,
	input wire logic extreme_calc_polarity_mode,
	input wire logic balance_switch_diag_scan,
	input wire logic [AUXES-1:0] aux_reference_select,
	input wire logic [AUXES-1:0] aux_pin_generic_io_enable,
	input wire logic aux_pin_two_wire_enable,
	output spc_pkg::spc_cell_ctrl_t cell_ctrl
);
	// Reset decode of the stored defaults, so no cell drops out of the extremes after reset
	localparam spc_pkg::spc_cell_ctrl_t CTRL_RESET = '{
		extreme_include: ~(spc_pkg::POL_CELL_RESET ^ {14{spc_pkg::POL_MODE_RESET}}),
		fault_mask: 14'h0000,
		bipolar_threshold: spc_pkg::POL_CELL_RESET,
		comparator_enable: ~spc_pkg::POL_CELL_RESET,
		aux_absolute: spc_pkg::AUX_REF_RESET
	};
	spc_pkg::spc_cell_ctrl_t st_reg;
	spc_pkg::spc_cell_ctrl_t st_next;
	logic [CELLS-1:0] inc_w, mask_w, thr_w, cmp_w;
	logic [AUXES-1:0] abs_w;

	genvar i;
	generate
		for (i = 0; i < CELLS; i++) begin : g_cell
			assign inc_w[i] = cell_bipolar[i] == extreme_calc_polarity_mode;
			assign mask_w[i] = cell_bipolar[i] & balance_switch_diag_scan;
			assign thr_w[i] = cell_bipolar[i];
			assign cmp_w[i] = !cell_bipolar[i];
		end
		for (i = 0; i < AUXES; i++) begin : g_aux
			// Ignored channels fall back to ratiometric; the stored bit is untouched
			assign abs_w[i] = aux_reference_select[i] && !aux_pin_generic_io_enable[i]
				&& !(aux_pin_two_wire_enable && i <= spc_pkg::TWO_WIRE_MSB);
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		st_next.extreme_include = inc_w;
		st_next.fault_mask = mask_w;
		st_next.bipolar_threshold = thr_w;
		st_next.comparator_enable = cmp_w;
		st_next.aux_absolute = abs_w;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_reg <= CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cell_ctrl = st_reg;
endmodule

// [test/tb_scan_polarity_aux_config.sv]
// Self-checking testbench for the scan polarity and auxiliary configuration block
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module tb_scan_polarity_aux_config;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	spc_pkg::spc_bus_req_t bus_req = '0;
	logic [15:0] bus_rdata;
	logic scan_request = 1'b0;
	logic scan_done = 1'b0;
	logic auto_mode = 1'b0;
	logic other_scan_active = 1'b0;
	logic balance_switch_diag_scan = 1'b0;
	logic [5:0] aux_pin_generic_io_enable = 6'h00;
	logic aux_pin_two_wire_enable = 1'b0;
	spc_pkg::spc_cell_ctrl_t cell_ctrl;
	logic [13:0] cell_bipolar;
	logic extreme_calc_polarity_mode;
	logic thermistor_bias_output;
	logic high_voltage_charge_pump;
	logic conversion_release;
	logic settle_busy;
	logic irq;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [15:0] rd_val;
	logic [15:0] pol_wr;
	// Edge patterns: lowest, highest, all and alternating cells
	logic [13:0] pol_cells [4] = '{14'h0001, 14'h2000, 14'h3FFF, 14'h1555};
	logic pol_mode [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
	// Generic I/O mask, two-wire enable, expected absolute channels
	logic [12:0] aux_tab [4] = '{13'h003F, 13'h082F, 13'h007C, 13'h105C};

	always #2 ref_clk = ~ref_clk;

	spc_config_top #(.UNIT_CYCLES(4)) dut (
		.ref_clk(ref_clk),
		.reset(reset),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.scan_request(scan_request),
		.scan_done(scan_done),
		.auto_mode(auto_mode),
		.other_scan_active(other_scan_active),
		.balance_switch_diag_scan(balance_switch_diag_scan),
		.aux_pin_generic_io_enable(aux_pin_generic_io_enable),
		.aux_pin_two_wire_enable(aux_pin_two_wire_enable),
		.cell_ctrl(cell_ctrl),
		.cell_bipolar(cell_bipolar),
		.extreme_calc_polarity_mode(extreme_calc_polarity_mode),
		.thermistor_bias_output(thermistor_bias_output),
		.high_voltage_charge_pump(high_voltage_charge_pump),
		.conversion_release(conversion_release),
		.settle_busy(settle_busy),
		.irq(irq)
	);

	// Tasks start and end in the time step of a rising edge
	task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
		@(posedge ref_clk);
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [15:0] exp);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1;
		rd_val = bus_rdata;
		`CHK(rd_val, exp)
		@(posedge ref_clk);
	endtask

	// Write, then read back on the very next cycle with no idle gap
	task automatic write_read(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] exp);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		check_reg(a, exp);
	endtask

	// Counts cycles from the request edge to the release pulse
	task automatic run_scan(input int n, input logic other);
		int k;
		other_scan_active <= other;
		scan_request <= 1'b1;
		@(posedge ref_clk);
		scan_request <= 1'b0;
		k = 1;
		#1;
		`CHK(thermistor_bias_output, 1'b1)
		while (conversion_release !== 1'b1 && k < 300) begin
			if (k == 2 && n > 0) begin
				`CHK(settle_busy, 1'b1)
				`CHK(high_voltage_charge_pump, !other)
			end
			@(posedge ref_clk);
			#1;
			k++;
		end
		`CHK(k, 2 + n * 4)
		@(posedge ref_clk);
		#1;
		`CHK(conversion_release, 1'b0)
		@(posedge ref_clk);
	endtask

	task automatic finish_scan;
		scan_done <= 1'b1;
		@(posedge ref_clk);
		scan_done <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#40000;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
		`CHK(cell_ctrl.extreme_include, 14'h3FFF)
		`CHK(cell_ctrl.comparator_enable, 14'h3FFF)
		@(posedge ref_clk);
		check_reg(spc_pkg::ADDR_POLARITY, 16'h0000);
		check_reg(spc_pkg::ADDR_AUX_REF, 16'h0000);
		check_reg(spc_pkg::ADDR_SETTLE, 16'h0000);
		bus_write(8'h62, 16'hFFFF);
		check_reg(8'h62, 16'h0000);
		#1;
		`CHK(cell_ctrl.extreme_include, 14'h3FFF)
		`CHK(cell_ctrl.comparator_enable, 14'h3FFF)
		`CHK(thermistor_bias_output, 1'b1)
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			pol_wr = {pol_mode[i], 1'h1, pol_cells[i]};
			write_read(spc_pkg::ADDR_POLARITY, pol_wr, {pol_mode[i], 1'h0, pol_cells[i]});
			#1;
			`CHK(cell_bipolar, pol_cells[i])
			`CHK(extreme_calc_polarity_mode, pol_mode[i])
			`CHK(cell_ctrl.extreme_include, pol_mode[i] ? pol_cells[i] : ~pol_cells[i])
			`CHK(cell_ctrl.bipolar_threshold, pol_cells[i])
			`CHK(cell_ctrl.comparator_enable, ~pol_cells[i])
			`CHK(cell_ctrl.fault_mask, 14'h0000)
			@(posedge ref_clk);
			balance_switch_diag_scan <= 1'b1;
			repeat (2) @(posedge ref_clk);
			#1;
			`CHK(cell_ctrl.fault_mask, pol_cells[i])
			@(posedge ref_clk);
			balance_switch_diag_scan <= 1'b0;
		end
		bus_write(spc_pkg::ADDR_AUX_REF, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			aux_pin_generic_io_enable <= aux_tab[i][12:7];
			aux_pin_two_wire_enable <= aux_tab[i][6];
			check_reg(spc_pkg::ADDR_AUX_REF, 16'h003F);
			#1;
			`CHK(cell_ctrl.aux_absolute, aux_tab[i][5:0])
			@(posedge ref_clk);
		end
		aux_pin_generic_io_enable <= 6'h00;
		aux_pin_two_wire_enable <= 1'b0;
		bus_write(spc_pkg::ADDR_AUX_REF, 16'h0015);
		@(posedge ref_clk);
		#1;
		`CHK(cell_ctrl.aux_absolute, 6'h15)
		@(posedge ref_clk);
		bus_write(spc_pkg::ADDR_SETTLE, 16'hFFFF);
		check_reg(spc_pkg::ADDR_SETTLE, 16'h03FF);
		bus_write(spc_pkg::ADDR_SETTLE, 16'h0003);
		auto_mode <= 1'b1;
		@(posedge ref_clk);
		#1;
		`CHK(thermistor_bias_output, 1'b0)
		@(posedge ref_clk);
		run_scan(3, 1'b0);
		check_reg(spc_pkg::ADDR_STATUS, 16'h0001);
		// Request while converting is dropped and flagged
		scan_request <= 1'b1;
		@(posedge ref_clk);
		scan_request <= 1'b0;
		@(posedge ref_clk);
		check_reg(spc_pkg::ADDR_STATUS, 16'h0003);
		#1;
		`CHK(irq, 1'b0)
		@(posedge ref_clk);
		bus_write(spc_pkg::ADDR_MASK, 16'h0002);
		#1;
		`CHK(irq, 1'b1)
		@(posedge ref_clk);
		bus_write(spc_pkg::ADDR_STATUS, 16'h0003);
		check_reg(spc_pkg::ADDR_STATUS, 16'h0000);
		#1;
		`CHK(irq, 1'b0)
		@(posedge ref_clk);
		finish_scan();
		#1;
		`CHK(thermistor_bias_output, 1'b0)
		@(posedge ref_clk);
		bus_write(spc_pkg::ADDR_SETTLE, 16'h0002);
		run_scan(2, 1'b1);
		finish_scan();
		bus_write(spc_pkg::ADDR_SETTLE, 16'h0000);
		run_scan(0, 1'b0);
		finish_scan();
		final_report();
	end
endmodule
